// ==== hw/level_sync3.sv ====
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser; the output follows once stages two and three agree
module level_sync3 #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output var logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    // Shift chain; stage one feeds only stage two
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1_reg <= RESET_VALUE;
            stage2_reg <= RESET_VALUE;
            stage3_reg <= RESET_VALUE;
        end
        else
        begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // Per-bit agreement filter rejects a one-cycle glitch
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    sync_out[i] <= RESET_VALUE[i];
                else if (stage2_reg[i] == stage3_reg[i])
                    sync_out[i] <= stage3_reg[i];
            end
        end
    endgenerate

endmodule // level_sync3

`default_nettype wire

// ==== hw/pll_two_status_synth_zero_ctrl.sv ====
// What this block does
// - Bits 7:4 of the rank register hold reference seven's rank for loop two, 0000 best, 1111 worst.
// - Bits 3:0 of the same register hold reference six's rank with the same ordering.
// - Status bit 0 is high whenever loop two is in holdover.
// - Status bit 1 is high while loop two is locked to its reference.
// - Status bit 2 is high when loop two's selected reference has failed, and it resets high.
// - Enable bit 0 drives synthesizer zero's first clock output, else that pin floats.
// - Enable bit 1 drives synthesizer zero's second clock output, else that pin floats.
// - Enable bit 2 drives synthesizer zero's first frame pulse, else that pin floats.
// - Enable bit 3 drives synthesizer zero's second frame pulse, else that pin floats.
// - Enable bit 6 picks loop one (0) or loop two (1) as synthesizer zero's source.
// - Enable bit 7 is synthesizer zero's master enable.
`timescale 1ns/1ps
`default_nettype none

module pll_two_status_synth_zero_ctrl (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // Wishbone classic slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Loop two state from the mode machine, asynchronous
    input wire logic LOOP_TWO_HOLDOVER,
    input wire logic LOOP_TWO_LOCK,
    input wire logic LOOP_TWO_REF_FAIL,
    // Reference ranks towards the selector
    output logic [3:0] REF_SEVEN_RANK,
    output logic [3:0] REF_SIX_RANK,
    // Synthesizer zero control
    output logic SYNTH0_ENABLE,
    output logic SYNTH0_LOOP_SELECT,
    // Raw synthesizer zero waveforms, same clock
    input wire logic SYNTH0_CLOCK_A_RAW,
    input wire logic SYNTH0_CLOCK_B_RAW,
    input wire logic SYNTH0_PULSE_A_RAW,
    input wire logic SYNTH0_PULSE_B_RAW,
    // Synthesizer zero pins, value and output enable
    output logic SYNTH0_CLOCK_A_O,
    output logic SYNTH0_CLOCK_A_OE,
    output logic SYNTH0_CLOCK_B_O,
    output logic SYNTH0_CLOCK_B_OE,
    output logic SYNTH0_PULSE_A_O,
    output logic SYNTH0_PULSE_A_OE,
    output logic SYNTH0_PULSE_B_O,
    output logic SYNTH0_PULSE_B_OE,
    // Interrupt
    output logic IRQ
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    pll_two_synth_pkg::bus_state_t bus_state_reg;
    pll_two_synth_pkg::bus_state_t bus_state_next;
    pll_two_synth_pkg::loop_status_t status_live;
    pll_two_synth_pkg::loop_status_t status_prev_reg;
    pll_two_synth_pkg::output_enable_t output_enable_reg;
    logic [7:0] ref_rank_reg;
    logic [pll_two_synth_pkg::STATUS_BITS-1:0] irq_status_reg;
    logic [pll_two_synth_pkg::STATUS_BITS-1:0] irq_mask_reg;
    logic [pll_two_synth_pkg::STATUS_BITS-1:0] irq_events;
    logic [pll_two_synth_pkg::DRIVE_BITS-1:0] raw_wave;
    logic [pll_two_synth_pkg::DRIVE_BITS-1:0] drive_en;
    logic [pll_two_synth_pkg::DRIVE_BITS-1:0] pin_value_reg;
    logic [pll_two_synth_pkg::DRIVE_BITS-1:0] pin_oe_reg;
    logic [31:0] read_data_reg;
    logic [31:0] read_mux;
    logic [5:0] access_idx;
    logic bus_req;
    logic bus_take;
    logic bus_write;
    logic bus_read;

    // Index of the addressed register from a byte address
    function automatic logic [5:0] word_index(input logic [7:0] byte_adr);
        word_index = byte_adr[pll_two_synth_pkg::ADR_IDX_MSB:pll_two_synth_pkg::ADR_IDX_LSB];
    endfunction

    // True when the addressed word is the given register
    function automatic logic hits(input logic [5:0] idx, input logic [5:0] target);
        hits = (idx == target);
    endfunction

    // ------------------------------------------------------------
    // Loop two status input synchronisation
    // ------------------------------------------------------------

    // Fail bit starts high so a read straight after reset sees the default
    // The loop state comes from another timing domain, so software sees a
    // change only three to four cycles after it happens
    level_sync3 #(
        .WIDTH(pll_two_synth_pkg::STATUS_BITS),
        .RESET_VALUE(pll_two_synth_pkg::RST_STATUS[pll_two_synth_pkg::STATUS_BITS-1:0])
    ) u_status_sync (
        .clk(SYS_CLK),
        .rst_n(RESETN),
        .async_in({LOOP_TWO_REF_FAIL, LOOP_TWO_LOCK, LOOP_TWO_HOLDOVER}),
        .sync_out(status_live)
    );

    // ------------------------------------------------------------
    // Wishbone classic slave
    // ------------------------------------------------------------

    // Request is taken only from idle, so each strobe gets exactly one ack
    // A write without byte lane 0 is acked but changes nothing
    assign bus_req = WB_CYC_I && WB_STB_I;
    assign bus_take = bus_req && (bus_state_reg == pll_two_synth_pkg::BUS_IDLE);
    assign bus_write = bus_take && WB_WE_I && WB_SEL_I[0];
    assign bus_read = bus_take && !WB_WE_I;
    assign access_idx = word_index(WB_ADR_I);

    // Ack is one cycle; the master must drop stb before the next request
    always_comb
    begin
        bus_state_next = bus_state_reg;
        case (bus_state_reg)
            pll_two_synth_pkg::BUS_IDLE:
                if (bus_req)
                    bus_state_next = pll_two_synth_pkg::BUS_ACK;
            pll_two_synth_pkg::BUS_ACK:
                bus_state_next = pll_two_synth_pkg::BUS_IDLE;
            default:
                bus_state_next = pll_two_synth_pkg::BUS_IDLE;
        endcase
    end

    // Bus state register
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
            bus_state_reg <= pll_two_synth_pkg::BUS_IDLE;
        else
            bus_state_reg <= bus_state_next;
    end

    assign WB_ACK_O = (bus_state_reg == pll_two_synth_pkg::BUS_ACK);

    // Read multiplexer; unmapped words read as zero and still ack
    always_comb
    begin
        read_mux = 32'h0000_0000;
        case (access_idx)
            pll_two_synth_pkg::IDX_REF_RANK_C:
                read_mux[7:0] = ref_rank_reg;
            pll_two_synth_pkg::IDX_STATUS:
                read_mux[pll_two_synth_pkg::STATUS_BITS-1:0] = status_live;
            pll_two_synth_pkg::IDX_OUTPUT_ENABLE:
                read_mux[7:0] = output_enable_reg;
            pll_two_synth_pkg::IDX_IRQ_STATUS:
                read_mux[pll_two_synth_pkg::STATUS_BITS-1:0] = irq_status_reg;
            pll_two_synth_pkg::IDX_IRQ_MASK:
                read_mux[pll_two_synth_pkg::STATUS_BITS-1:0] = irq_mask_reg;
            default:
                read_mux = 32'h0000_0000;
        endcase
    end

    // Read data is captured when the request is taken and held through ack
    // Holding the word until the next read costs a register but keeps it stable
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
            read_data_reg <= 32'h0000_0000;
        else if (bus_read)
            read_data_reg <= read_mux;
    end

    assign WB_DAT_O = read_data_reg;

    // ------------------------------------------------------------
    // Reference rank register
    // ------------------------------------------------------------

    // Both nibbles are plain storage; the code value is the rank itself
    // The selector reads the ranks straight from this register, with no copy
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
            ref_rank_reg <= pll_two_synth_pkg::RST_REF_RANK_C;
        else if (bus_write && hits(access_idx, pll_two_synth_pkg::IDX_REF_RANK_C))
            ref_rank_reg <= WB_DAT_I[7:0];
    end

    assign REF_SEVEN_RANK = ref_rank_reg[pll_two_synth_pkg::RANK_SEVEN_MSB:
                                         pll_two_synth_pkg::RANK_SEVEN_LSB];
    assign REF_SIX_RANK = ref_rank_reg[pll_two_synth_pkg::RANK_SIX_MSB:
                                       pll_two_synth_pkg::RANK_SIX_LSB];

    // ------------------------------------------------------------
    // Synthesizer zero enable register
    // ------------------------------------------------------------

    // Reserved bits are masked so they always hold their default; status
    // register writes have no decode here and are simply acked
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
            output_enable_reg <= pll_two_synth_pkg::RST_OUTPUT_ENABLE;
        else if (bus_write && hits(access_idx, pll_two_synth_pkg::IDX_OUTPUT_ENABLE))
            output_enable_reg <= (WB_DAT_I[7:0] & pll_two_synth_pkg::OUTPUT_ENABLE_WMASK)
                | (pll_two_synth_pkg::RST_OUTPUT_ENABLE
                & ~pll_two_synth_pkg::OUTPUT_ENABLE_WMASK);
    end

    assign SYNTH0_ENABLE = output_enable_reg.master;
    assign SYNTH0_LOOP_SELECT = output_enable_reg.loop_select;

    // ------------------------------------------------------------
    // Synthesizer zero pin drivers
    // ------------------------------------------------------------

    assign raw_wave = {SYNTH0_PULSE_B_RAW, SYNTH0_PULSE_A_RAW,
                       SYNTH0_CLOCK_B_RAW, SYNTH0_CLOCK_A_RAW};
    assign drive_en = {output_enable_reg.pulse_b, output_enable_reg.pulse_a,
                       output_enable_reg.clock_b, output_enable_reg.clock_a};

    // Value and enable are registered together so both reach the pad aligned
    // A disabled synthesizer holds its driven pins low rather than floating
    // them, so the pin enables stay purely per output
    genvar k;
    generate
        for (k = 0; k < pll_two_synth_pkg::DRIVE_BITS; k++)
        begin : g_pin
            always_ff @(posedge SYS_CLK or negedge RESETN)
            begin
                if (!RESETN)
                begin
                    pin_value_reg[k] <= 1'b0;
                    pin_oe_reg[k] <= 1'b0;
                end
                else
                begin
                    pin_value_reg[k] <= raw_wave[k] && output_enable_reg.master;
                    pin_oe_reg[k] <= drive_en[k];
                end
            end
        end
    endgenerate

    assign SYNTH0_CLOCK_A_O = pin_value_reg[pll_two_synth_pkg::EN_CLOCK_A];
    assign SYNTH0_CLOCK_A_OE = pin_oe_reg[pll_two_synth_pkg::EN_CLOCK_A];
    assign SYNTH0_CLOCK_B_O = pin_value_reg[pll_two_synth_pkg::EN_CLOCK_B];
    assign SYNTH0_CLOCK_B_OE = pin_oe_reg[pll_two_synth_pkg::EN_CLOCK_B];
    assign SYNTH0_PULSE_A_O = pin_value_reg[pll_two_synth_pkg::EN_PULSE_A];
    assign SYNTH0_PULSE_A_OE = pin_oe_reg[pll_two_synth_pkg::EN_PULSE_A];
    assign SYNTH0_PULSE_B_O = pin_value_reg[pll_two_synth_pkg::EN_PULSE_B];
    assign SYNTH0_PULSE_B_OE = pin_oe_reg[pll_two_synth_pkg::EN_PULSE_B];

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------

    // Previous status for edge detection; starts at the reset image so
    // no event fires at release
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
            status_prev_reg <= pll_two_synth_pkg::RST_STATUS[pll_two_synth_pkg::STATUS_BITS-1:0];
        else
            status_prev_reg <= status_live;
    end

    // Events: entry into holdover, lock gained, selected reference failed
    // Only rising edges count; losing a condition raises no interrupt
    assign irq_events = status_live & ~status_prev_reg;

    // Sticky status, cleared by a read of itself; a new event wins the clear
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
            irq_status_reg <= pll_two_synth_pkg::RST_IRQ_STATUS[pll_two_synth_pkg::STATUS_BITS-1:0];
        else if (bus_read && hits(access_idx, pll_two_synth_pkg::IDX_IRQ_STATUS))
            irq_status_reg <= irq_events;
        else
            irq_status_reg <= irq_status_reg | irq_events;
    end

    // Mask register, same layout as the status
    // Mask bits above the three events do not exist and read as zero
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
            irq_mask_reg <= pll_two_synth_pkg::RST_IRQ_MASK[pll_two_synth_pkg::STATUS_BITS-1:0];
        else if (bus_write && hits(access_idx, pll_two_synth_pkg::IDX_IRQ_MASK))
            irq_mask_reg <= WB_DAT_I[pll_two_synth_pkg::STATUS_BITS-1:0];
    end

    // Level output while any enabled sticky bit stands
    // Kept combinational so a clear by read drops the line at the taking edge
    assign IRQ = |(irq_status_reg & irq_mask_reg);

endmodule // pll_two_status_synth_zero_ctrl

`default_nettype wire

// ==== hw/pll_two_synth_pkg.sv ====
`default_nettype none

package pll_two_synth_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_REF_RANK_C = 6'h34;
    localparam logic [5:0] IDX_STATUS = 6'h35;
    localparam logic [5:0] IDX_OUTPUT_ENABLE = 6'h36;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h3E;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h3F;

    // Byte address bits that carry the index
    localparam int ADR_IDX_LSB = 2;
    localparam int ADR_IDX_MSB = 7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_REF_RANK_C = 8'h76;
    localparam logic [7:0] RST_STATUS = 8'h04;
    localparam logic [7:0] RST_OUTPUT_ENABLE = 8'h8F;
    localparam logic [7:0] RST_IRQ_MASK = 8'h00;
    localparam logic [7:0] RST_IRQ_STATUS = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RANK_SEVEN_MSB = 7;
    localparam int RANK_SEVEN_LSB = 4;
    localparam int RANK_SIX_MSB = 3;
    localparam int RANK_SIX_LSB = 0;
    localparam int ST_HOLDOVER = 0;
    localparam int ST_LOCK = 1;
    localparam int ST_REF_FAIL = 2;
    localparam int STATUS_BITS = 3;
    localparam int EN_CLOCK_A = 0;
    localparam int EN_CLOCK_B = 1;
    localparam int EN_PULSE_A = 2;
    localparam int EN_PULSE_B = 3;
    localparam int EN_LOOP_SEL = 6;
    localparam int EN_MASTER = 7;
    localparam int DRIVE_BITS = 4;

    // Writable bits of the enable register; 5:4 stay at their default
    localparam logic [7:0] OUTPUT_ENABLE_WMASK = 8'hCF;

    // Loop select encoding
    localparam logic LOOP_SEL_ONE = 1'b0;
    localparam logic LOOP_SEL_TWO = 1'b1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic ref_fail;
        logic lock;
        logic holdover;
    } loop_status_t;

    typedef struct packed {
        logic master;
        logic loop_select;
        logic [1:0] reserved;
        logic pulse_b;
        logic pulse_a;
        logic clock_b;
        logic clock_a;
    } output_enable_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;

endpackage

`default_nettype wire

// ==== tb/pll_two_status_synth_zero_ctrl_properties.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Port-level properties of the loop two status and synth zero block
// ------------------------------------------------------------
module pll_two_status_synth_zero_ctrl_properties (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // Register bus
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // Loop two state
    input wire logic LOOP_TWO_HOLDOVER,
    input wire logic LOOP_TWO_LOCK,
    input wire logic LOOP_TWO_REF_FAIL,
    // Control outputs
    input wire logic [3:0] REF_SEVEN_RANK,
    input wire logic [3:0] REF_SIX_RANK,
    input wire logic SYNTH0_ENABLE,
    input wire logic SYNTH0_LOOP_SELECT,
    // Synthesizer zero pins
    input wire logic SYNTH0_CLOCK_A_RAW,
    input wire logic SYNTH0_CLOCK_A_O,
    input wire logic SYNTH0_CLOCK_A_OE,
    input wire logic SYNTH0_CLOCK_B_OE,
    input wire logic SYNTH0_PULSE_A_OE,
    input wire logic SYNTH0_PULSE_B_OE
);
    logic take;
    logic wr_rank;
    logic wr_en;
    logic rd_status;

    // Request qualifiers; a write without lane 0 changes nothing
    assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr_rank = take && WB_WE_I && WB_SEL_I[0] && WB_ADR_I[7:2] == 6'h34;
    assign wr_en = take && WB_WE_I && WB_SEL_I[0] && WB_ADR_I[7:2] == 6'h36;
    assign rd_status = take && !WB_WE_I && WB_ADR_I[7:2] == 6'h35;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESETN);

    // Loop inputs quiet long enough for the synchroniser to settle
    sequence quiet_loop;
        $stable({LOOP_TWO_REF_FAIL, LOOP_TWO_LOCK, LOOP_TWO_HOLDOVER})[*6];
    endsequence

    // Bus answer and register effects tied to the taking edge, plus ack width and clock pin gating by the master enable
    ack_single_pulse_a:
        assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack stayed high for two cycles");
    ack_answer_a:
        assert property (take |=> WB_ACK_O)
        else $error("request taken without ack one cycle later");
    seven_rank_a:
        assert property (wr_rank |=> REF_SEVEN_RANK == $past(WB_DAT_I[7:4]))
        else $error("reference seven rank differs from written nibble");
    six_rank_a:
        assert property (wr_rank |=> REF_SIX_RANK == $past(WB_DAT_I[3:0]))
        else $error("reference six rank differs from written nibble");
    drive_enable_a:
        assert property (wr_en |=> ##1 {SYNTH0_PULSE_B_OE, SYNTH0_PULSE_A_OE,
            SYNTH0_CLOCK_B_OE, SYNTH0_CLOCK_A_OE} == $past(WB_DAT_I[3:0], 2))
        else $error("pin drive enables differ from written bits");
    loop_source_a:
        assert property (wr_en |=> SYNTH0_LOOP_SELECT == $past(WB_DAT_I[6]))
        else $error("loop select differs from written bit");
    master_enable_a:
        assert property (wr_en |=> SYNTH0_ENABLE == $past(WB_DAT_I[7]))
        else $error("master enable differs from written bit");
    pin_gating_a:
        assert property (RESETN |=> SYNTH0_CLOCK_A_O ==
            ($past(SYNTH0_CLOCK_A_RAW) && $past(SYNTH0_ENABLE)))
        else $error("clock pin not gated by master enable");
    status_live_a:
        assert property (quiet_loop ##0 rd_status |=> WB_DAT_O == {29'h0,
            $past(LOOP_TWO_REF_FAIL), $past(LOOP_TWO_LOCK), $past(LOOP_TWO_HOLDOVER)})
        else $error("status read differs from settled loop state");

    // Main scenarios reached
    cover property (wr_rank);
    cover property (wr_en && !WB_DAT_I[7]);
    cover property (rd_status && LOOP_TWO_REF_FAIL);
endmodule // pll_two_status_synth_zero_ctrl_properties

`default_nettype wire

// ==== tb/pll_two_status_synth_zero_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Register bench for the loop two status and synth zero block
// ------------------------------------------------------------
module pll_two_status_synth_zero_ctrl_tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [2:0] loop_in = 3'h4;
    logic [3:0] wave_reg = 4'h0;
    logic [7:0] en_tab [4] = '{8'h00, 8'hFF, 8'h4A, 8'h85};
    logic [31:0] rd;
    logic [7:0] v;
    wire logic [31:0] dat_o;
    wire logic ack;
    wire logic [3:0] rank7;
    wire logic [3:0] rank6;
    wire logic syn_en;
    wire logic syn_sel;
    wire logic irq;
    wire logic [3:0] pin_o;
    wire logic [3:0] pin_oe;
    int fails = 0;
    int samples_checked = 0;

    pll_two_status_synth_zero_ctrl dut (
        .SYS_CLK(sys_clk), .RESETN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .LOOP_TWO_HOLDOVER(loop_in[0]), .LOOP_TWO_LOCK(loop_in[1]),
        .LOOP_TWO_REF_FAIL(loop_in[2]), .REF_SEVEN_RANK(rank7), .REF_SIX_RANK(rank6),
        .SYNTH0_ENABLE(syn_en), .SYNTH0_LOOP_SELECT(syn_sel),
        .SYNTH0_CLOCK_A_RAW(wave_reg[0]), .SYNTH0_CLOCK_B_RAW(wave_reg[1]),
        .SYNTH0_PULSE_A_RAW(wave_reg[2]), .SYNTH0_PULSE_B_RAW(wave_reg[3]),
        .SYNTH0_CLOCK_A_O(pin_o[0]), .SYNTH0_CLOCK_A_OE(pin_oe[0]),
        .SYNTH0_CLOCK_B_O(pin_o[1]), .SYNTH0_CLOCK_B_OE(pin_oe[1]),
        .SYNTH0_PULSE_A_O(pin_o[2]), .SYNTH0_PULSE_A_OE(pin_oe[2]),
        .SYNTH0_PULSE_B_O(pin_o[3]), .SYNTH0_PULSE_B_OE(pin_oe[3]), .IRQ(irq)
    );

    // 10 MHz system clock
    always #50 sys_clk = ~sys_clk;

    // Raw synthesizer waveforms, each pin toggling at its own rate
    always @(posedge sys_clk)
        wave_reg <= wave_reg + 4'h1;

    // Verdict and run end, shared by the tests and the watchdog
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            fails++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    // One classic cycle; read data is taken at the edge where ack is seen
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
        input logic [3:0] s);
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat_i <= {24'h0, d};
        do
        begin
            @(posedge sys_clk);
        end
        while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, d, 4'h1);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        bus(a, 1'b0, 8'h00, 4'h1);
        check(rd, {24'h0, e});
    endtask

    // Main sequence
    initial
    begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdc(8'hD0, 8'h76);
        rdc(8'hD4, 8'h04);
        rdc(8'hD8, 8'h8F);
        rdc(8'hFC, 8'h00);
        rdc(8'h40, 8'h00);
        check({24'h0, rank7, rank6}, 32'h76);
        // Every rank code in both nibbles; a write without lane 0 is dropped
        for (int c = 0; c < 16; c++)
        begin
            v = {c[3:0], ~c[3:0]};
            wr(8'hD0, v);
            rdc(8'hD0, v);
            check({24'h0, rank7, rank6}, {24'h0, v});
        end
        bus(8'hD0, 1'b1, 8'h12, 4'h0);
        rdc(8'hD0, 8'hF0);
        // Drive enables, source, master and the reserved pair
        foreach (en_tab[i])
        begin
            v = en_tab[i];
            wr(8'hD8, v);
            rdc(8'hD8, v & 8'hCF);
            check({28'h0, pin_oe}, {28'h0, v[3:0]});
            check({30'h0, syn_en, syn_sel}, {30'h0, v[7:6]});
            if (!v[7])
                check({28'h0, pin_o}, 32'h0);
        end
        // Last entry leaves the master on: pins show the waves one edge late
        @(negedge sys_clk);
        check({28'h0, pin_o}, {28'h0, wave_reg - 4'h1});
        // Status ignores writes and follows the loop state both ways
        wr(8'hD4, 8'hFF);
        rdc(8'hD4, 8'h04);
        for (int k = 0; k < 8; k++)
        begin
            @(posedge sys_clk);
            loop_in <= k[2:0];
            repeat (6) @(posedge sys_clk);
            rdc(8'hD4, {5'h0, k[2:0]});
        end
        // Interrupt: masked event, unmask, clear on read
        loop_in <= 3'h0;
        repeat (6) @(posedge sys_clk);
        bus(8'hF8, 1'b0, 8'h00, 4'h1);
        rdc(8'hF8, 8'h00);
        loop_in <= 3'h1;
        repeat (6) @(posedge sys_clk);
        check({31'h0, irq}, 32'h0);
        wr(8'hFC, 8'h01);
        @(negedge sys_clk);
        check({31'h0, irq}, 32'h1);
        rdc(8'hF8, 8'h01);
        @(negedge sys_clk);
        check({31'h0, irq}, 32'h0);
        rdc(8'hFC, 8'h01);
        print_verdict();
    end

    // Watchdog: the tests need well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        fails++;
        print_verdict();
    end
endmodule // pll_two_status_synth_zero_ctrl_tb

bind pll_two_status_synth_zero_ctrl pll_two_status_synth_zero_ctrl_properties props (
    .SYS_CLK, .RESETN, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I,
    .WB_DAT_O, .WB_ACK_O, .LOOP_TWO_HOLDOVER, .LOOP_TWO_LOCK, .LOOP_TWO_REF_FAIL,
    .REF_SEVEN_RANK, .REF_SIX_RANK, .SYNTH0_ENABLE, .SYNTH0_LOOP_SELECT,
    .SYNTH0_CLOCK_A_RAW, .SYNTH0_CLOCK_A_O, .SYNTH0_CLOCK_A_OE, .SYNTH0_CLOCK_B_OE,
    .SYNTH0_PULSE_A_OE, .SYNTH0_PULSE_B_OE
);

`default_nettype wire
